// [logic/ssc_pkg.sv]
// Package for the synchronous serial control and status block
package ssc_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  OFF_CONTROL      = 8'h20;
    localparam logic [7:0]  OFF_STATUS       = 8'h21;
    localparam logic [7:0]  OFF_BUFFER       = 8'h22;
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;
    localparam logic [7:0]  RX_BUFFER_RESET  = 8'h00;
    // Control field positions
    localparam int          RUN_BIT          = 7;
    localparam int          FORCE_STOP_BIT   = 6;
    localparam int          MODE_LSB         = 4;
    localparam int          ORDER_BIT        = 3;
    localparam int          CLKSEL_LSB       = 0;
    // Status field positions
    localparam int          ACTIVE_BIT       = 7;
    localparam int          COUNT_BIT        = 6;
    localparam int          TX_EMPTY_BIT     = 5;
    localparam int          RX_FULL_BIT      = 4;
    localparam int          TX_UNDER_BIT     = 3;
    localparam int          RX_OVER_BIT      = 2;
    localparam logic [7:0]  STATUS_RESET     = 8'h20;
    // Clock select codes
    localparam logic [2:0]  CLKSEL_SLOWEST   = 3'h0;
    localparam logic [2:0]  CLKSEL_EXTERNAL  = 3'h7;
    localparam int          FC_DIV_LOG2_000  = 12;
    localparam int          FC_DIV_LOG2_110  = 3;
    localparam int          FS_DIV_LOG2      = 4;
    localparam int          BITS_PER_BYTE    = 8;

    typedef enum logic [1:0] {
        SSC_MODE_TX    = 2'h0,
        SSC_MODE_RX    = 2'h1,
        SSC_MODE_TXRX  = 2'h2,
        SSC_MODE_RSVD  = 2'h3
    } ssc_mode_e;

    typedef enum logic [1:0] {
        SSC_IDLE  = 2'h0,
        SSC_LOW   = 2'h1,
        SSC_HIGH  = 2'h3,
        SSC_WAIT  = 2'h2
    } ssc_state_e;

    typedef struct packed {
        logic       run;
        logic       force_stop;
        ssc_mode_e  mode;
        logic       lsb_first;
        logic [2:0] clksel;
    } ssc_control_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ssc_bus_s;
endpackage : ssc_pkg

// [logic/ssc_top.sv]
// Synchronous serial interface control, status and shifter
`timescale 1ns/10ps
// Behaviour
// (RQ1) Run bit starts and stops transfers
// (RQ2) Force stop halts, then self-clears
// (RQ3) Force stop resets run, status, buffers
// (RQ4) Mode: 00 tx, 01 rx, 10 both
// (RQ5) Order bit: 0 MSB first, 1 LSB
// (RQ6) Codes 000-110 pick internal divided clocks
// (RQ7) Code 111 uses external pin clock
// (RQ8) Software changes setup only when idle
// (RQ9) Active flag and clocks 1-7 flag
// (RQ10) Tx empty flag shows buffer empty
// (RQ11) Rx full flag shows buffer full
// (RQ12) External clock tx underrun sets flag
// (RQ13) External clock rx overrun sets flag
// (RQ14) Zero write clears error, one ignored
// (RQ15) Run clear keeps error flags
// (RQ16) Tx write while not empty discarded
// (RQ17) Software checks empty before writing
// (RQ18) No read-modify-write on tx buffer
// (RQ19) Reset: status 0x20, control zero
// (RQ20) Shift out falling, sample rising edge
// (RQ21) Internal clock idles high, auto-waits
// (RQ22) Active flag rises on first falling edge
// (RQ23) Tx load sets empty, raises interrupt
// (RQ24) Rx read clears full, tx write clears empty
module ssc_top
    import ssc_pkg::*;
#(
    parameter int FS_RATIO = 16       // System clocks per low-frequency tick
) (
    input  wire logic              clock_i,      // System clock
    input  wire logic              rst_n_i,      // Async reset, active low
    input  wire logic [ADDR_W-1:0] addr_i,       // Register address
    input  wire logic [DATA_W-1:0] wdata_i,      // Write data
    input  wire logic              wr_i,         // Write strobe
    input  wire logic              rd_i,         // Read strobe
    output logic      [DATA_W-1:0] rdata_o,      // Read data, next cycle
    input  wire logic              slow_mode_i,  // Slow operation mode
    input  wire logic              divider_stage_select_i, // Timebase option
    input  wire logic              sck_i,        // Serial clock pin input
    output logic                   sck_o,        // Serial clock pin output
    output logic                   sck_oe_o,     // Serial clock pin drive
    input  wire logic              sdi_i,        // Serial data in pin
    output logic                   sdo_o,        // Serial data out pin
    output logic                   serial_interrupt_request_o // Irq pulse
);
    ssc_bus_s     bus;
    ssc_control_s ctl_reg;
    logic [DATA_W-1:0] tx_buf_reg, rx_buf_reg, shift_reg;
    logic        tx_empty_reg, rx_full_reg, tx_under_reg, rx_over_reg;
    logic        active_reg, count_flag_reg;
    logic [3:0]  bit_cnt_reg;
    logic [11:0] div_reg;
    logic [$clog2(FS_RATIO)-1:0] fs_cnt_reg;
    logic [3:0]  fs_div_reg;
    logic        sck_s1_reg, sck_s2_reg, sck_s3_reg, sdi_s1_reg, sdi_s2_reg;
    logic        sck_out_reg, tick;
    logic        stop_now;
    ssc_state_e  state_reg;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input ssc_bus_s b, input logic [7:0] off);
        return b.addr == off;
    endfunction : hit

    wire wr_ctl   = bus.wr && hit(bus, OFF_CONTROL);
    wire wr_stat  = bus.wr && hit(bus, OFF_STATUS);
    wire wr_tx    = bus.wr && hit(bus, OFF_BUFFER);
    wire rd_rx    = bus.rd && hit(bus, OFF_BUFFER);
    wire ext_clk  = ctl_reg.clksel == CLKSEL_EXTERNAL;                // RQ7
    wire tx_on    = ctl_reg.mode != SSC_MODE_RX;
    wire rx_on    = ctl_reg.mode != SSC_MODE_TX;
    wire force_go = wr_ctl && wdata_i[FORCE_STOP_BIT];

    // Control register; force stop self-clears one cycle later
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_reg <= ssc_control_s'(CONTROL_RESET);                // RQ19
        end else if (ctl_reg.force_stop) begin
            ctl_reg.force_stop <= 1'b0;                               // RQ2
            ctl_reg.run        <= 1'b0;                               // RQ3
        end else if (wr_ctl) begin
            ctl_reg <= ssc_control_s'(wdata_i);                       // RQ1
        end
    end
    assign stop_now = ctl_reg.force_stop;

    // Pin synchronisers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_s1_reg <= 1'b1;
            sck_s2_reg <= 1'b1;
            sck_s3_reg <= 1'b1;
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg <= sck_i;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            sdi_s1_reg <= sdi_i;
            sdi_s2_reg <= sdi_s1_reg;
        end
    end

    // Internal clock dividers: fc stages and a low-frequency tick
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg    <= '0;
            fs_cnt_reg <= '0;
            fs_div_reg <= '0;
        end else begin
            div_reg <= div_reg + 12'h001;
            if (fs_cnt_reg == $bits(fs_cnt_reg)'(FS_RATIO - 1)) begin
                fs_cnt_reg <= '0;
                fs_div_reg <= fs_div_reg + 4'h1;
            end else begin
                fs_cnt_reg <= fs_cnt_reg + 1'b1;
            end
        end
    end
    wire fs_tick = fs_cnt_reg == $bits(fs_cnt_reg)'(FS_RATIO - 1);

    // Half-period tick of the selected internal serial clock
    always_comb begin
        logic [3:0] lg;
        lg   = 4'(FC_DIV_LOG2_000);
        tick = 1'b0;
        if (ctl_reg.clksel == CLKSEL_SLOWEST &&
            (slow_mode_i || divider_stage_select_i)) begin
            tick = fs_tick && (fs_div_reg[FS_DIV_LOG2-2:0] == '0);    // RQ6
        end else begin
            if (ctl_reg.clksel != CLKSEL_SLOWEST)
                lg = 4'(FC_DIV_LOG2_110 + 6) - 4'(ctl_reg.clksel);    // RQ6
            tick = (div_reg & ((12'h001 << (lg - 4'h1)) - 12'h001)) == '0;
        end
    end

    wire ext_fall = sck_s3_reg && !sck_s2_reg;
    wire ext_rise = !sck_s3_reg && sck_s2_reg;
    wire data_ok  = (!tx_on || !tx_empty_reg) && (!rx_on || !rx_full_reg);
    wire int_fall = !ext_clk && tick &&
                    (state_reg == SSC_IDLE || state_reg == SSC_HIGH) &&
                    ctl_reg.run && (bit_cnt_reg != 4'h0 || data_ok);   // RQ21
    wire int_rise = !ext_clk && tick && state_reg == SSC_LOW;
    wire do_fall  = ext_clk ? (ext_fall && ctl_reg.run) : int_fall;
    wire do_rise  = ext_clk ? (ext_rise && active_reg) : int_rise;
    wire byte_start = do_fall && bit_cnt_reg == 4'h0;
    wire byte_end   = do_rise && bit_cnt_reg == 4'(BITS_PER_BYTE);

    // Internal clock state: idle high, low half, high half
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= SSC_IDLE;
            sck_out_reg <= 1'b1;
        end else if (stop_now || ext_clk) begin
            state_reg   <= SSC_IDLE;
            sck_out_reg <= 1'b1;
        end else begin
            case (state_reg)
                SSC_IDLE, SSC_HIGH: begin
                    if (int_fall) begin
                        state_reg   <= SSC_LOW;
                        sck_out_reg <= 1'b0;
                    end else if (!ctl_reg.run && bit_cnt_reg == 4'h0) begin
                        state_reg <= SSC_IDLE;                        // RQ1
                    end
                end
                SSC_LOW: begin
                    if (int_rise) begin
                        state_reg   <= SSC_HIGH;
                        sck_out_reg <= 1'b1;
                    end
                end
                default: state_reg <= SSC_IDLE;
            endcase
        end
    end

    // Shifter, bit counter and progress flags
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg      <= '0;
            bit_cnt_reg    <= '0;
            active_reg     <= 1'b0;
            count_flag_reg <= 1'b0;
            sdo_o          <= 1'b1;
        end else if (stop_now) begin
            bit_cnt_reg    <= '0;                                     // RQ2
            active_reg     <= 1'b0;
            count_flag_reg <= 1'b0;
            sdo_o          <= 1'b1;
        end else begin
            if (do_fall) begin
                active_reg <= 1'b1;                                   // RQ22
                if (bit_cnt_reg == 4'h0) begin
                    logic [DATA_W-1:0] d;
                    d = tx_buf_reg;
                    shift_reg      <= d;
                    sdo_o          <= ctl_reg.lsb_first ? d[0] : d[7]; // RQ5
                    bit_cnt_reg    <= 4'h1;
                    count_flag_reg <= 1'b1;                           // RQ9
                end else begin
                    sdo_o <= ctl_reg.lsb_first ? shift_reg[0] : shift_reg[7]; // RQ20
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'(BITS_PER_BYTE - 1))
                        count_flag_reg <= 1'b0;                       // RQ9
                end
            end
            if (do_rise && bit_cnt_reg != 4'h0) begin
                shift_reg <= ctl_reg.lsb_first ?
                             {sdi_s2_reg, shift_reg[7:1]} :
                             {shift_reg[6:0], sdi_s2_reg};           // RQ20
                if (bit_cnt_reg == 4'(BITS_PER_BYTE)) begin
                    bit_cnt_reg <= '0;
                    if (!ctl_reg.run)
                        active_reg <= 1'b0;                           // RQ9
                end
            end
            if (!ctl_reg.run && bit_cnt_reg == 4'h0 && !do_fall)
                active_reg <= 1'b0;                                   // RQ1
        end
    end

    // Buffers and flags; hardware set wins over software clear
    wire [DATA_W-1:0] rx_byte = ctl_reg.lsb_first ?
                                {sdi_s2_reg, shift_reg[7:1]} :
                                {shift_reg[6:0], sdi_s2_reg};
    wire tx_take  = byte_start && tx_on && !tx_empty_reg;
    wire under    = byte_start && tx_on && tx_empty_reg && ext_clk;
    wire rx_done  = byte_end && rx_on;
    wire over     = rx_done && rx_full_reg && ext_clk;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buf_reg   <= '0;
            rx_buf_reg   <= RX_BUFFER_RESET;
            tx_empty_reg <= STATUS_RESET[TX_EMPTY_BIT];               // RQ19
            rx_full_reg  <= STATUS_RESET[RX_FULL_BIT];
            tx_under_reg <= STATUS_RESET[TX_UNDER_BIT];
            rx_over_reg  <= STATUS_RESET[RX_OVER_BIT];
            serial_interrupt_request_o <= 1'b0;
        end else if (stop_now) begin
            tx_buf_reg   <= '0;                                       // RQ3
            rx_buf_reg   <= RX_BUFFER_RESET;
            tx_empty_reg <= STATUS_RESET[TX_EMPTY_BIT];
            rx_full_reg  <= STATUS_RESET[RX_FULL_BIT];
            tx_under_reg <= STATUS_RESET[TX_UNDER_BIT];
            rx_over_reg  <= STATUS_RESET[RX_OVER_BIT];
            serial_interrupt_request_o <= 1'b0;
        end else begin
            serial_interrupt_request_o <= tx_take || (rx_done && !rx_full_reg); // RQ23
            if (tx_take)
                tx_empty_reg <= 1'b1;                                 // RQ23
            else if (wr_tx && tx_empty_reg) begin
                tx_buf_reg   <= wdata_i;                              // RQ16
                tx_empty_reg <= 1'b0;                                 // RQ24
            end
            if (rx_done && !rx_full_reg) begin
                rx_buf_reg  <= rx_byte;
                rx_full_reg <= 1'b1;                                  // RQ11
            end else if (rd_rx)
                rx_full_reg <= 1'b0;                                  // RQ24
            if (under)
                tx_under_reg <= 1'b1;                                 // RQ12
            else if (wr_stat && !wdata_i[TX_UNDER_BIT])
                tx_under_reg <= 1'b0;                                 // RQ14
            if (over)
                rx_over_reg <= 1'b1;                                  // RQ13
            else if (wr_stat && !wdata_i[RX_OVER_BIT])
                rx_over_reg <= 1'b0;                                  // RQ14 RQ15
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (bus.rd) begin
            if (hit(bus, OFF_CONTROL))
                rdata_o <= ctl_reg;
            else if (hit(bus, OFF_STATUS))
                rdata_o <= {active_reg, count_flag_reg, tx_empty_reg,
                            rx_full_reg, tx_under_reg, rx_over_reg, 2'b00}; // RQ10
            else if (hit(bus, OFF_BUFFER))
                rdata_o <= rx_buf_reg;
            else
                rdata_o <= '0;
        end else begin
            rdata_o <= '0;
        end
    end

    // Pin drive: internal clock drives the pin, external leaves it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_o    <= 1'b1;
            sck_oe_o <= 1'b0;
        end else begin
            sck_o    <= sck_out_reg;                                  // RQ21
            sck_oe_o <= !ext_clk;                                     // RQ7
        end
    end
endmodule : ssc_top

// [bench/ssc_top_assertions.sv]
// Port-level assertions for the serial control block
`timescale 1ns/10ps
module ssc_top_assertions
    import ssc_pkg::*;
#(
    parameter int FS_RATIO = 16                 // Tick ratio
) (
    input wire logic              clock_i,      // Clock
    input wire logic              rst_n_i,      // Reset
    input wire logic [ADDR_W-1:0] addr_i,       // Address
    input wire logic [DATA_W-1:0] wdata_i,      // Write data
    input wire logic              wr_i,         // Write
    input wire logic              rd_i,         // Read
    input wire logic [DATA_W-1:0] rdata_o,      // Read data
    input wire logic              sck_oe_o,     // Clock drive
    input wire logic              serial_interrupt_request_o // Irq
);
    logic run_sh;
    logic ctl_w;
    logic st_w;
    logic st_r;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    assign ctl_w = wr_i && addr_i == OFF_CONTROL;
    assign st_w  = wr_i && addr_i == OFF_STATUS;
    assign st_r  = rd_i && addr_i == OFF_STATUS;
    // Shadow of the run bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_sh <= 1'b0;
        end else if (ctl_w) begin
            run_sh <= wdata_i[RUN_BIT] && !wdata_i[FORCE_STOP_BIT];
        end
    end
    property p_stat_low; st_r |=> rdata_o[1:0] == 2'b00; endproperty
    a_stat_low: assert property (p_stat_low) else $error("status low bits set");
    property p_ext_nodrv; ctl_w && wdata_i[2:0] == CLKSEL_EXTERNAL |-> ##2 !sck_oe_o; endproperty
    a_ext_nodrv: assert property (p_ext_nodrv) else $error("clock driven");
    property p_irq; serial_interrupt_request_o |=> !serial_interrupt_request_o; endproperty
    a_irq: assert property (p_irq) else $error("irq longer than one cycle");
    property p_tx_clr; wr_i && addr_i == OFF_BUFFER && !run_sh ##1 st_r
        |=> !rdata_o[TX_EMPTY_BIT]; endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx empty still set");
    property p_force; ctl_w && wdata_i[FORCE_STOP_BIT] && !wdata_i[RUN_BIT] ##2 st_r
        |=> rdata_o == STATUS_RESET; endproperty
    a_force: assert property (p_force) else $error("status not reset");
    property p_ctl; ctl_w && !wdata_i[FORCE_STOP_BIT] ##1 rd_i && addr_i == OFF_CONTROL
        |=> rdata_o == $past(wdata_i, 2); endproperty
    a_ctl: assert property (p_ctl) else $error("control readback");
    property p_err_clr; st_w && wdata_i[3:2] == 2'b00 ##1 st_r
        |=> rdata_o[3:2] == 2'b00; endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flags kept");
    property p_err_keep; st_r ##1 st_w && wdata_i[3:2] == 2'b11 ##1 st_r
        |=> (rdata_o & 8'h0C) == ($past(rdata_o, 2) & 8'h0C); endproperty
    a_err_keep: assert property (p_err_keep) else $error("error flags changed");
endmodule : ssc_top_assertions

bind ssc_top ssc_top_assertions #(.FS_RATIO(FS_RATIO)) i_ssc_top_assertions (
    .clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sck_oe_o,
    .serial_interrupt_request_o
);

// [bench/ssc_far_model.sv]
// Far-side serial device model
`timescale 1ns/10ps
module ssc_far_model (
    input  wire logic clock_i,     // System clock
    input  wire logic sck_oe_i,    // Block drives clock pin
    input  wire logic sck_out_i,   // Block clock value
    input  wire logic sdo_i,       // Block serial out
    input  wire logic lsb_first_i, // Bit order
    output logic      sck_wire_o,  // Resolved clock pin
    output logic      sdi_o        // Serial data to block
);
    logic       ext_sck = 1'b1;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte = 8'h00;
    int         nbits = 0;
    time        t_fall = 0;
    time        per = 0;
    initial sdi_o = 1'b1;
    // Pin idles high outside frames
    assign sck_wire_o = sck_oe_i ? sck_out_i : ext_sck;
    always @(negedge sck_wire_o) begin
        per = $time - t_fall;
        t_fall = $time;
        sdi_o <= lsb_first_i ? tx_byte[0] : tx_byte[7];
        tx_byte <= lsb_first_i ? {1'b0, tx_byte[7:1]} : {tx_byte[6:0], 1'b0};
    end
    always @(posedge sck_wire_o) begin
        rx_byte <= lsb_first_i ? {sdo_i, rx_byte[7:1]} : {rx_byte[6:0], sdo_i};
        nbits = nbits + 1;
    end
    // Eight external pulses, half period in system cycles
    task automatic clock_byte(input int half);
        repeat (8) begin
            repeat (half) @(posedge clock_i);
            ext_sck <= 1'b0;
            repeat (half) @(posedge clock_i);
            ext_sck <= 1'b1;
        end
    endtask : clock_byte
endmodule : ssc_far_model

// [bench/ssc_tb_top.sv]
// Self-checking testbench for the serial control block
`timescale 1ns/10ps
module ssc_tb_top;
    import ssc_pkg::*;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic              wr_s = 1'b0;
    logic              rd_s = 1'b0;
    logic              lsb = 1'b0;
    logic              slow = 1'b0;
    logic              dvs = 1'b0;
    logic              irq;
    int                irq_n = 0;
    logic [DATA_W-1:0] rdata;
    logic              sck_o;
    logic              sck_oe_o;
    logic              sck_w;
    logic              sdi;
    logic              sdo;
    logic [7:0]        s;
    int                bad_count = 0;
    int                checks = 0;
    int                cyc = 0;
    always #2.5 clock_i = ~clock_i;
    ssc_top #(.FS_RATIO(2)) i_ssc_top (
        .clock_i, .rst_n_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
        .rdata_o(rdata), .slow_mode_i(slow), .divider_stage_select_i(dvs),
        .sck_i(sck_w), .sck_o, .sck_oe_o, .sdi_i(sdi), .sdo_o(sdo),
        .serial_interrupt_request_o(irq)
    );
    // Interrupt pulse counter
    always @(posedge clock_i) if (irq === 1'b1) irq_n++;
    ssc_far_model i_ssc_far_model (
        .clock_i, .sck_oe_i(sck_oe_o), .sck_out_i(sck_o), .sdo_i(sdo),
        .lsb_first_i(lsb), .sck_wire_o(sck_w), .sdi_o(sdi)
    );
    task automatic conclude();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle, launched just after an edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr_s <= w;
        rd_s <= r;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        #1;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus(1'b0, 1'b1, a, 8'h00);
        d = rdata;
    endtask : rd
    task automatic nop(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : nop
    task automatic t_reset();
        rd(OFF_CONTROL, s);
        chk(s, 8'h00);
        rd(OFF_STATUS, s);
        chk(s, 8'h20);
        rd(OFF_BUFFER, s);
        chk(s, 8'h00);
        wr(OFF_CONTROL, 8'h2E);
        rd(OFF_CONTROL, s);
        chk(s, 8'h2E);
    endtask : t_reset
    task automatic t_tx(input logic l, input logic [2:0] c, input logic [7:0] d);
        lsb = l;
        i_ssc_far_model.nbits = 0;
        irq_n = 0;
        wr(OFF_BUFFER, d);
        rd(OFF_STATUS, s);
        chk(s & 8'h20, 8'h00);
        wr(OFF_BUFFER, ~d);
        wr(OFF_CONTROL, {4'h8, l, c});
        for (int i = 0; i < 3000 && i_ssc_far_model.nbits < 8; i++) nop(1);
        nop(4);
        chk(i_ssc_far_model.rx_byte, d);
        if (c == 3'h0 && (slow || dvs))
            chk(8'(i_ssc_far_model.per / 5), 8'(2 * 16));
        else
            chk(8'(i_ssc_far_model.per / 5), 8'(1 << (9 - c)));
        chk(8'(irq_n), 8'h01);
        chk({7'h00, sck_o}, 8'h01);
        rd(OFF_STATUS, s);
        chk(s & 8'h60, 8'h20);
        wr(OFF_CONTROL, {4'h0, l, c});
    endtask : t_tx
    task automatic t_rx();
        lsb = 1'b0;
        s = 8'h00;
        i_ssc_far_model.tx_byte = 8'h96;
        wr(OFF_CONTROL, 8'h96);
        for (int i = 0; i < 300 && s[RX_FULL_BIT] !== 1'b1; i++) rd(OFF_STATUS, s);
        wr(OFF_CONTROL, 8'h16);
        rd(OFF_BUFFER, s);
        chk(s, 8'h96);
        rd(OFF_STATUS, s);
        chk(s & 8'h10, 8'h00);
    endtask : t_rx
    task automatic t_ext();
        wr(OFF_CONTROL, 8'hA7);
        nop(1);
        i_ssc_far_model.tx_byte = 8'h5A;
        i_ssc_far_model.clock_byte(8);
        nop(6);
        rd(OFF_STATUS, s);
        chk(s & 8'h7C, 8'h38);
        i_ssc_far_model.tx_byte = 8'hC3;
        i_ssc_far_model.clock_byte(4);
        nop(6);
        rd(OFF_STATUS, s);
        chk(s & 8'h7C, 8'h3C);
        rd(OFF_BUFFER, s);
        chk(s, 8'h5A);
        rd(OFF_STATUS, s);
        wr(OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, s);
        chk(s & 8'h3C, 8'h2C);
        wr(OFF_CONTROL, 8'h27);
        rd(OFF_STATUS, s);
        chk(s & 8'h0C, 8'h0C);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, s);
        chk(s & 8'h0C, 8'h00);
        wr(OFF_CONTROL, 8'hA7);
        nop(1);
        i_ssc_far_model.clock_byte(8);
        nop(6);
        wr(OFF_BUFFER, 8'h11);
        rd(OFF_STATUS, s);
        chk(s & 8'h3C, 8'h18);
        wr(OFF_CONTROL, 8'h47);
        nop(1);
        rd(OFF_STATUS, s);
        chk(s, 8'h20);
        rd(OFF_CONTROL, s);
        chk(s, 8'h07);
        rd(OFF_BUFFER, s);
        chk(s, 8'h00);
        nop(1);
    endtask : t_ext
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        t_reset();
        t_tx(1'b0, 3'h6, 8'hA5);
        t_tx(1'b1, 3'h5, 8'h3C);
        slow = 1'b1;
        t_tx(1'b0, 3'h0, 8'h69);
        slow = 1'b0;
        dvs = 1'b1;
        t_tx(1'b1, 3'h0, 8'h2D);
        dvs = 1'b0;
        t_rx();
        t_ext();
        conclude();
    end
endmodule : ssc_tb_top
